// File: src/system_reset_sequencer.sv
// system reset sequencer: filtering, async/sync reset, flags, exit sequence
`timescale 1ns/1ps
module system_reset_sequencer #(
    parameter int FLASH_INIT_CYC = reset_seq_pkg::FLASH_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic reset_request_in,
    input wire logic reset_mode_select_pin,
    input wire logic external_access_select,
    input wire logic bidir_reset_enable,
    input wire logic software_reset_instruction,
    input wire logic watchdog_overflow_in,
    input wire logic end_of_init_instruction,
    input wire logic [15:0] config_port_in,
    output logic reset_output,
    output logic internal_reset_out,
    output logic bus_tristate_out,
    output logic config_port_pullup_out,
    output logic reset_request_pulldown_out,
    output logic [15:0] system_config_register,
    output reset_seq_pkg::flags_t flags_out,
    output reset_seq_pkg::strobes_t strobes_out,
    output logic [23:0] fetch_addr_out,
    output logic [15:0] flash_read_data_out
);
    reset_seq_pkg::state_t state_ff, nxt_state;
    logic [reset_seq_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [reset_seq_pkg::CNT_W-1:0] filt_ff;
    logic filtered_reset_in_ff;
    logic [31:0] flash_cnt_ff;
    logic flash_done_ff;
    logic sw_req_ff;
    logic wd_req_ff;
    reset_seq_pkg::flags_t nxt_flags;

    // two half-clocks per cycle
    // counter load for n cycles: zero is the last cycle, so n cycles load n-1
    function automatic logic [reset_seq_pkg::CNT_W-1:0] cyc(input int n);
        cyc = reset_seq_pkg::CNT_W'(n - 1);
    endfunction

    // spike filter
    // reset low only counts after the filter time; shorter spikes vanish
    wire raw_low = !reset_request_in;
    wire filt_full = filt_ff >= reset_seq_pkg::CNT_W'(reset_seq_pkg::FILT_CYC);
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            filt_ff <= reset_seq_pkg::CNT_ZERO;
            filtered_reset_in_ff <= 1'b0;
        end else begin
            filt_ff <= raw_low ? (filt_full ? filt_ff : filt_ff + reset_seq_pkg::CNT_ONE)
                               : reset_seq_pkg::CNT_ZERO;
            filtered_reset_in_ff <= raw_low && filt_full;
        end
    end
    wire rst_low = filtered_reset_in_ff;

    // bidirectional gate
    // with mode pin low, software and watchdog events do not pull the input
    wire internal_evt = software_reset_instruction || watchdog_overflow_in;
    wire drive_pin = bidir_reset_enable && reset_mode_select_pin;

    wire go_async = rst_low && !reset_mode_select_pin;
    wire in_reset = state_ff != reset_seq_pkg::ST_RUN;
    wire cnt_done = cnt_ff == reset_seq_pkg::CNT_ZERO;
    wire [reset_seq_pkg::CNT_W-1:0] cnt_dec = cnt_ff - reset_seq_pkg::CNT_ONE;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_done ? cnt_ff : cnt_dec;
        if (go_async) begin
            nxt_state = reset_seq_pkg::ST_ASYNC;
        end else begin
            case (state_ff)
                reset_seq_pkg::ST_RUN: begin
                    if (rst_low) begin
                        nxt_state = reset_seq_pkg::ST_DETECT;
                        nxt_cnt = cyc(reset_seq_pkg::DETECT_CYC + reset_seq_pkg::HOLD_CYC);
                    end else if (internal_evt) begin
                        nxt_state = reset_seq_pkg::ST_SEQ;
                        nxt_cnt = cyc(reset_seq_pkg::SEQ_CYC);
                    end
                end
                reset_seq_pkg::ST_ASYNC: begin
                    if (!rst_low) begin
                        nxt_state = reset_seq_pkg::ST_EXIT;
                        nxt_cnt = cyc(reset_seq_pkg::EXIT_CYC);
                    end
                end
                reset_seq_pkg::ST_DETECT: begin
                    if (cnt_done) begin
                        nxt_state = reset_seq_pkg::ST_SEQ;
                        nxt_cnt = cyc(reset_seq_pkg::SEQ_CYC);
                    end
                end
                reset_seq_pkg::ST_SEQ: begin
                    if (cnt_done) begin
                        nxt_state = reset_seq_pkg::ST_WAIT;
                        nxt_cnt = cyc(reset_seq_pkg::WAIT_CYC);
                    end
                end
                reset_seq_pkg::ST_WAIT: begin
                    if (cnt_done) begin
                        nxt_state = rst_low ? reset_seq_pkg::ST_HOLD_LOW : reset_seq_pkg::ST_EXIT;
                        nxt_cnt = cyc(reset_seq_pkg::EXIT_CYC);
                    end
                end
                reset_seq_pkg::ST_HOLD_LOW: begin
                    if (!rst_low) begin
                        nxt_state = reset_seq_pkg::ST_EXIT;
                        nxt_cnt = cyc(reset_seq_pkg::EXIT_CYC);
                    end
                end
                reset_seq_pkg::ST_EXIT: begin
                    if (cnt_done) begin
                        nxt_state = external_access_select ? reset_seq_pkg::ST_FLASH
                                                           : reset_seq_pkg::ST_RUN;
                    end
                end
                reset_seq_pkg::ST_FLASH: begin
                    if (flash_done_ff) begin
                        nxt_state = reset_seq_pkg::ST_RUN;
                    end
                end
                default: nxt_state = reset_seq_pkg::ST_ASYNC;
            endcase
        end
    end

    // clockless async entry
    // reset default is the async state so power-on needs no clock edge
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= reset_seq_pkg::ST_ASYNC;
            cnt_ff <= reset_seq_pkg::CNT_ZERO;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // flash init runs on its own from input release, regardless of cpu state
    wire flash_restart = rst_low;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flash_cnt_ff <= 32'h00000000;
            flash_done_ff <= 1'b0;
        end else if (flash_restart) begin
            flash_cnt_ff <= 32'h00000000;
            flash_done_ff <= 1'b0;
        end else if (!flash_done_ff) begin
            flash_cnt_ff <= flash_cnt_ff + 32'h00000001;
            flash_done_ff <= flash_cnt_ff >= 32'(FLASH_INIT_CYC - 1);
        end
    end

    wire [15:0] nxt_flash_data = flash_done_ff ? reset_seq_pkg::FLASH_BLANK
        : (flash_cnt_ff < 32'(FLASH_INIT_CYC / 2) ? reset_seq_pkg::FLASH_BLANK
                                                  : reset_seq_pkg::FLASH_LATE);

    // sample what kind of reset is running
    wire enter_async = go_async && state_ff != reset_seq_pkg::ST_ASYNC;
    wire wait_end = state_ff == reset_seq_pkg::ST_WAIT && cnt_done && !go_async;
    wire from_pin_ff_path = sw_req_ff || wd_req_ff;

    // flags clear on end of init
    // set beats clear when both land in the same cycle
    always_comb begin
        nxt_flags = flags_out;
        if (end_of_init_instruction) begin
            nxt_flags = '0;
        end
        if (enter_async) begin
            nxt_flags.long_hw_reset_flag = 1'b1;
            nxt_flags.short_hw_reset_flag = 1'b1;
            nxt_flags.software_reset_flag = 1'b1;
        end
        if (wait_end && !from_pin_ff_path) begin
            nxt_flags.long_hw_reset_flag = rst_low;
            nxt_flags.short_hw_reset_flag = 1'b1;
            nxt_flags.software_reset_flag = 1'b1;
        end
        if (wait_end && from_pin_ff_path) begin
            nxt_flags.software_reset_flag = 1'b1;
            nxt_flags.watchdog_reset_flag = wd_req_ff;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_out <= '0;
            flags_out.power_on_flag <= 1'b1;
            flags_out.long_hw_reset_flag <= 1'b1;
            flags_out.short_hw_reset_flag <= 1'b1;
            flags_out.software_reset_flag <= 1'b1;
            sw_req_ff <= 1'b0;
            wd_req_ff <= 1'b0;
        end else begin
            flags_out <= nxt_flags;
            if (state_ff == reset_seq_pkg::ST_RUN && internal_evt && !rst_low) begin
                sw_req_ff <= software_reset_instruction;
                wd_req_ff <= watchdog_overflow_in;
            end else if (state_ff == reset_seq_pkg::ST_RUN) begin
                sw_req_ff <= 1'b0;
                wd_req_ff <= 1'b0;
            end
        end
    end

    wire nxt_in_reset = nxt_state != reset_seq_pkg::ST_RUN;
    wire leaving = in_reset && !nxt_in_reset;
    wire nxt_async = nxt_state == reset_seq_pkg::ST_ASYNC;
    wire nxt_pull = nxt_in_reset && from_pin_ff_path && drive_pin
        && (nxt_state == reset_seq_pkg::ST_SEQ);
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reset_output <= 1'b0;
            internal_reset_out <= 1'b1;
            bus_tristate_out <= 1'b1;
            config_port_pullup_out <= 1'b1;
            reset_request_pulldown_out <= 1'b0;
            system_config_register <= reset_seq_pkg::CFG_DEFAULT;
            strobes_out <= '0;
            fetch_addr_out <= reset_seq_pkg::START_ADDR;
            flash_read_data_out <= reset_seq_pkg::FLASH_BLANK;
        end else begin
            reset_output <= !nxt_in_reset;
            internal_reset_out <= nxt_in_reset;
            bus_tristate_out <= nxt_in_reset;
            config_port_pullup_out <= nxt_async;
            reset_request_pulldown_out <= nxt_pull;
            if (leaving) begin
                system_config_register <= config_port_in;
                fetch_addr_out <= reset_seq_pkg::START_ADDR;
            end
            strobes_out <= '0;
            flash_read_data_out <= nxt_flash_data;
        end
    end

    chk_flash_hold_release: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff == reset_seq_pkg::ST_FLASH && !flash_done_ff && !go_async)
        |=> internal_reset_out)
        else $error("internal reset released before flash init");

    chk_async_entry_now: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        go_async |=> state_ff == reset_seq_pkg::ST_ASYNC ##1 !reset_output)
        else $error("async reset not entered");

    chk_async_pin_default: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        state_ff == reset_seq_pkg::ST_ASYNC |=> config_port_pullup_out
        || state_ff != reset_seq_pkg::ST_ASYNC)
        else $error("config port not pulled high");

    chk_reset_out_match: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        reset_output != internal_reset_out && internal_reset_out == in_reset)
        else $error("reset output mismatch");

    sequence seq_start_s;
        $rose(state_ff == reset_seq_pkg::ST_SEQ);
    endsequence
    chk_seq_length: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        seq_start_s ##0 !go_async[*8] |-> state_ff == reset_seq_pkg::ST_SEQ)
        else $error("sequence ended early");

    chk_spike_reject: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(raw_low) ##1 !raw_low |=> !rst_low)
        else $error("spike passed filter");

    chk_flag_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        end_of_init_instruction && !enter_async && !wait_end |=> flags_out == '0)
        else $error("flags not cleared");

    chk_cfg_latch: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        leaving |=> system_config_register == $past(config_port_in))
        else $error("config not latched at exit");
endmodule // system_reset_sequencer

// File: inc/reset_seq_pkg.sv
// constants and carrier types of the system reset sequencer
package reset_seq_pkg;
    localparam int CLK_MHZ = 50;
    localparam int FILT_MIN_NS = 50;
    localparam int FILT_CYC = (FILT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int VALID_NS = 500;
    localparam int VALID_CYC = (VALID_NS * CLK_MHZ) / 1000;
    localparam int HCU_PER_CLK = 2;
    localparam int DETECT_HCU = 4;
    localparam int HOLD_HCU = 12;
    localparam int SEQ_HCU = 1024;
    localparam int WAIT_HCU = 8;
    localparam int EXIT_HCU = 3;
    localparam int DETECT_CYC = DETECT_HCU / HCU_PER_CLK;
    localparam int HOLD_CYC = HOLD_HCU / HCU_PER_CLK;
    localparam int SEQ_CYC = SEQ_HCU / HCU_PER_CLK;
    localparam int WAIT_CYC = WAIT_HCU / HCU_PER_CLK;
    localparam int EXIT_CYC = (EXIT_HCU + HCU_PER_CLK - 1) / HCU_PER_CLK;
    localparam int FLASH_MS = 1;
    localparam int FLASH_CYC = FLASH_MS * CLK_MHZ * 1000;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] FLASH_BLANK = 16'hFFFF;
    localparam logic [15:0] FLASH_LATE = 16'h009B;
    localparam logic [23:0] START_ADDR = 24'h000000;
    localparam logic [15:0] CFG_DEFAULT = 16'hFFFF;
    typedef enum logic [2:0] {
        ST_RUN, ST_ASYNC, ST_DETECT, ST_SEQ, ST_WAIT, ST_HOLD_LOW, ST_EXIT, ST_FLASH
    } state_t;
    typedef struct packed {
        logic power_on_flag;
        logic long_hw_reset_flag;
        logic short_hw_reset_flag;
        logic software_reset_flag;
        logic watchdog_reset_flag;
    } flags_t;
    typedef struct packed {
        logic ale_active;
        logic read_strobe_active;
        logic write_strobe_active;
    } strobes_t;
endpackage

// File: dv/board_reset_model.sv
// board-side reset circuitry driving the request pin and the mode pin
`timescale 1ns/1ps
module board_reset_model (
    input wire logic hold_low_in,
    input wire logic mode_low_in,
    input wire logic pulldown_in,
    output logic reset_request_out,
    output logic mode_pin_out
);
    // pulse length set by caller
    // request pin has a board pull-up, so a released pin reads high, never stale
    assign reset_request_out = (hold_low_in || pulldown_in) ? 1'b0 : 1'b1;
    assign mode_pin_out = mode_low_in ? 1'b0 : 1'b1;
endmodule // board_reset_model

// File: dv/system_reset_sequencer_tb_top.sv
// self-checking bench for the system reset sequencer
`timescale 1ns/1ps
module system_reset_sequencer_tb_top;
    localparam int FI = 20;
    localparam int MAXW = 1500;
    typedef struct {int n; bit ml; bit rs; logic [4:0] fl;} row_t;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b1;
    logic hold_low = 1'b1, mode_low = 1'b1, ext = 1'b1, bidir = 1'b0;
    logic sw = 1'b0, wd = 1'b0, eoi = 1'b0;
    logic [15:0] cfg = 16'hA5C3;
    logic req, mode, rst_out, ir, tri_o, pull_o, pd_o;
    logic [15:0] cfg_reg, flash_d;
    logic [23:0] fetch;
    reset_seq_pkg::flags_t flags;
    reset_seq_pkg::strobes_t strobes;
    int err_count = 0, checks = 0, c;
    bit saw, pd_seen;
    logic [15:0] f_first, f_last;
    row_t rows[5];

    board_reset_model board_reset_model_inst (.hold_low_in(hold_low), .mode_low_in(mode_low),
        .pulldown_in(pd_o), .reset_request_out(req), .mode_pin_out(mode));
    system_reset_sequencer #(.FLASH_INIT_CYC(FI)) system_reset_sequencer_inst (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reset_request_in(req),
        .reset_mode_select_pin(mode), .external_access_select(ext),
        .bidir_reset_enable(bidir), .software_reset_instruction(sw),
        .watchdog_overflow_in(wd), .end_of_init_instruction(eoi), .config_port_in(cfg),
        .reset_output(rst_out), .internal_reset_out(ir), .bus_tristate_out(tri_o),
        .config_port_pullup_out(pull_o), .reset_request_pulldown_out(pd_o),
        .system_config_register(cfg_reg), .flags_out(flags), .strobes_out(strobes),
        .fetch_addr_out(fetch), .flash_read_data_out(flash_d));

    initial begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cmp_vec(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int lo, input int hi, input string what);
        checks++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("BAD %0t %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask

    // bounded wait for internal reset release, counting cycles
    task automatic wait_release(input int min_c);
        c = 0;
        while (!(ir === 1'b0 && c >= min_c)) begin
            if (ir === 1'b1) saw = 1'b1;
            if (pd_o === 1'b1) pd_seen = 1'b1;
            if (c == 4) f_first = flash_d;
            if (ir === 1'b1) f_last = flash_d;
            step(1);
            c++;
            if (c > MAXW) begin
                err_count++;
                $display("BAD %0t reset release never came", $time);
                tally_and_finish();
            end
        end
    endtask

    task automatic clear_flags();
        eoi = 1'b1;
        step(1);
        eoi = 1'b0;
        step(1);
    endtask

    task automatic sw_event(input bit is_wd, input bit ml, input bit bd, input bit exp_pd);
        bidir = bd;
        mode_low = ml;
        sw = !is_wd;
        wd = is_wd;
        step(1);
        sw = 1'b0;
        wd = 1'b0;
        pd_seen = 1'b0;
        wait_release(20);
        cmp_bit(pd_seen, exp_pd, "request pulldown");
        cmp_bit(flags.software_reset_flag, 1'b1, "software flag");
        cmp_bit(flags.watchdog_reset_flag, is_wd, "watchdog flag");
        mode_low = 1'b0;
        clear_flags();
    endtask

    initial begin
        rows[0] = '{1, 1'b1, 1'b0, 5'b00000};
        rows[1] = '{2, 1'b1, 1'b0, 5'b00000};
        rows[2] = '{reset_seq_pkg::VALID_CYC + 2, 1'b1, 1'b1, 5'b01110};
        rows[3] = '{40, 1'b0, 1'b1, 5'b00110};
        rows[4] = '{600, 1'b0, 1'b1, 5'b01110};
        // no clock edge yet: async detection must not need one
        // a real falling edge, so the asynchronous reset branch fires
        #1;
        rst_b_in = 1'b0;
        #4;
        cmp_vec({rst_out, ir, tri_o, pull_o}, 24'h000007, "async reset state");
        cmp_vec(flags, 24'h00001E, "power-on flags");
        step(8);
        rst_b_in = 1'b1;
        step(10);
        hold_low = 1'b0;
        mode_low = 1'b0;
        // internal flash boot waits for flash init
        wait_release(1);
        cmp_cnt(c, FI, FI + 12, "flash init hold");
        cmp_vec(f_first, reset_seq_pkg::FLASH_BLANK, "early flash read");
        cmp_vec(f_last, reset_seq_pkg::FLASH_LATE, "late flash read");
        step(1);
        cmp_vec(cfg_reg, 24'h00A5C3, "latched config");
        cmp_vec(strobes, 24'h000000, "strobes inactive");
        cmp_vec(fetch, 24'h000000, "fetch address");
        cmp_vec({rst_out, tri_o}, 24'h000002, "outputs released");
        clear_flags();
        cmp_vec(flags, 24'h000000, "flags cleared");
        ext = 1'b0;
        cfg = 16'h3C5A;
        // ordinary pulses, mode pin and length per row
        foreach (rows[i]) begin
            hold_low = 1'b1;
            mode_low = rows[i].ml;
            step(rows[i].n);
            if (rows[i].rs) begin
                cmp_vec({rst_out, tri_o, pull_o}, {21'h0, 2'b01, rows[i].ml}, "in reset");
            end
            hold_low = 1'b0;
            mode_low = 1'b0;
            saw = (ir === 1'b1);
            wait_release(8);
            cmp_bit(saw, rows[i].rs, "reset taken");
            cmp_vec(flags, rows[i].fl, "reset flags");
            if (rows[i].rs) begin
                cmp_vec(cfg_reg, 24'h003C5A, "relatched config");
                cmp_bit(rst_out, 1'b1, "reset output released");
            end
            clear_flags();
        end
        // external boot: release soon after pin high
        hold_low = 1'b1;
        mode_low = 1'b1;
        step(reset_seq_pkg::VALID_CYC + 2);
        hold_low = 1'b0;
        mode_low = 1'b0;
        wait_release(1);
        cmp_cnt(c, 2, reset_seq_pkg::FILT_CYC + 6, "external boot exit");
        clear_flags();
        // mode pin falls low in mid sync sequence
        hold_low = 1'b1;
        step(100);
        mode_low = 1'b1;
        step(10);
        cmp_bit(pull_o, 1'b1, "turned asynchronous");
        hold_low = 1'b0;
        mode_low = 1'b0;
        wait_release(1);
        cmp_vec(flags, 24'h00000E, "async hw flags");
        clear_flags();
        // software resets with and without the bidir pulldown, watchdog resets without it
        sw_event(1'b0, 1'b1, 1'b1, 1'b0);
        sw_event(1'b0, 1'b0, 1'b1, 1'b1);
        sw_event(1'b1, 1'b1, 1'b1, 1'b0);
        sw_event(1'b1, 1'b0, 1'b0, 1'b0);
        // reset in mid-run returns default state at once
        step(1);
        rst_b_in = 1'b0;
        #1;
        cmp_vec({rst_out, ir, tri_o, pull_o}, 24'h000007, "mid-run reset");
        cmp_vec(flags, 24'h00001E, "mid-run reset flags");
        tally_and_finish();
    end
endmodule // system_reset_sequencer_tb_top
